// File: src/pfd_pkg.sv
package pfd_pkg;

  // Horizontal cycle landmarks of a 114-cycle scan line
  localparam logic [6:0] LINE_LAST_CYCLE    = 7'h71;
  localparam logic [6:0] SPECIAL_LAST_CYCLE = 7'h07;
  localparam logic [6:0] SUPPRESS_FIRST     = 7'h69;
  localparam logic [6:0] SUPPRESS_LAST      = 7'h6F;

  // Playfield start and stop cycles at zero scroll, eight cycles apart per width step;
  // stop minus start is a whole number of slow ring turns so the stop clear hits the bit
  localparam logic [6:0] START_NARROW = 7'h1A;
  localparam logic [6:0] START_NORMAL = 7'h12;
  localparam logic [6:0] START_WIDE   = 7'h0A;
  localparam logic [6:0] STOP_NARROW  = 7'h5A;
  localparam logic [6:0] STOP_NORMAL  = 7'h62;
  localparam logic [6:0] STOP_WIDE    = 7'h6A;

  // Width field of the fetch control register
  localparam logic [1:0] WIDTH_OFF    = 2'h0;
  localparam logic [1:0] WIDTH_NARROW = 2'h1;
  localparam logic [1:0] WIDTH_NORMAL = 2'h2;
  localparam logic [1:0] WIDTH_WIDE   = 2'h3;

  // Ring geometry and tap offsets
  localparam int unsigned DMA_RING_BITS   = 8;
  localparam int unsigned SHIFT_RING_BITS = 4;
  localparam int unsigned TAP_NAME        = 0;
  localparam int unsigned TAP_BITMAP      = 2;
  localparam int unsigned TAP_CHAR_DATA   = 3;
  localparam int unsigned GFX_BITS        = 8;

  localparam logic [3:0]  SHIFT_MASK_FAST = 4'hF;
  localparam logic [3:0]  SHIFT_MASK_MED  = 4'h5;
  localparam logic [3:0]  SHIFT_MASK_SLOW = 4'h1;
  localparam logic [15:0] ADDR_ALL_ONES   = 16'hFFFF;

  typedef enum logic [2:0] {
    RATE_FAST = 3'b001,
    RATE_MED  = 3'b010,
    RATE_SLOW = 3'b100
  } pfd_rate_e;

  function automatic pfd_rate_e pfd_fetch_rate(input logic [3:0] mode);
    case (mode)
      4'h8, 4'h9:                      pfd_fetch_rate = RATE_SLOW;
      4'h6, 4'h7, 4'hA, 4'hB, 4'hC:    pfd_fetch_rate = RATE_MED;
      default:                         pfd_fetch_rate = RATE_FAST;
    endcase
  endfunction : pfd_fetch_rate

  function automatic pfd_rate_e pfd_shift_rate(input logic [3:0] mode);
    case (mode)
      4'h8:       pfd_shift_rate = RATE_SLOW;
      4'h9, 4'hA: pfd_shift_rate = RATE_MED;
      default:    pfd_shift_rate = RATE_FAST;
    endcase
  endfunction : pfd_shift_rate

  function automatic logic pfd_one_bit_pixels(input logic [3:0] mode);
    case (mode)
      4'h6, 4'h7, 4'h9, 4'hB, 4'hC: pfd_one_bit_pixels = 1'b1;
      default:                      pfd_one_bit_pixels = 1'b0;
    endcase
  endfunction : pfd_one_bit_pixels

  function automatic logic pfd_char_mode(input logic [3:0] mode);
    pfd_char_mode = (mode >= 4'h2) && (mode <= 4'h7);
  endfunction : pfd_char_mode

endpackage : pfd_pkg

// File: src/pfd_playfield_dma.sv
// Contract
// - Fetch ring length two, four, eight by rate
// - Ring drives fetches and scan counter increments
// - Taps at 0, +2, +3 for name, bitmap, data
// - Inject one bit at start, clear at stop
// - Blank, jump, vertical blank clear whole ring
// - Four-bit shift ring, two steps per cycle
// - Cycles 0-7 clear shift ring and register
// - Shift ring started by data fetch, outlives stop
// - Fetch rate per mode table
// - Shift rate and pixel width per mode
// - Missed stop lets ring run into next line
// - No playfield bus fetch in cycles 105-111 and 0
// - Overlapping fetches AND addresses, share data
// - Refresh only when nothing else requests
// - Empty shift register outputs pixel 00
// - Clear attempted at width stop and wide stop
// - Two scroll clocks delay start/stop one cycle
// - Mismatched scroll phase leaves ring running
// - Late scroll or width writes miss stop
// - Ring physically eight bits, spill may recapture
// - Late fetches recaptured on switch to slow
// - Ring runs on repeated lines from buffer
// - Width field and scroll place start/stop
`timescale 1ns/1ps

module pfd_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [CW-1:0]               count;
  } pfd_fifo_state_s;

  pfd_fifo_state_s state_q;
  pfd_fifo_state_s state_d;
  logic            doPush;
  logic            doPop;

  assign inReady  = (state_q.count != CNT_FULL);
  assign outValid = (state_q.count != '0);
  assign outData  = state_q.mem[state_q.rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb begin
    state_d = state_q;
    if (doPush) begin
      state_d.mem[state_q.wrPtr] = inData;
      state_d.wrPtr = (state_q.wrPtr == PTR_LAST) ? '0 : state_q.wrPtr + 1'b1;
    end
    if (doPop) begin
      state_d.rdPtr = (state_q.rdPtr == PTR_LAST) ? '0 : state_q.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      state_d.count = state_q.count + 1'b1;
    end else if (doPop && !doPush) begin
      state_d.count = state_q.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end
endmodule : pfd_fifo

////////////////////////////////////////////////////////////////////////////////

module pfd_playfield_dma
  import pfd_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [6:0]  hposCycle,
  input  wire logic [3:0]  displayInstructionCode,
  input  wire logic        modeBlankOrJump,
  input  wire logic        verticalBlank,
  input  wire logic        firstScanLine,
  input  wire logic [1:0]  fetchControlReg,
  input  wire logic [3:0]  horizontalScrollReg,
  input  wire logic        mscLoad,
  input  wire logic [15:0] mscLoadAddr,
  input  wire logic [15:0] charDataAddr,
  input  wire logic        specialRequest,
  input  wire logic [15:0] specialAddr,
  input  wire logic        refreshWanted,
  input  wire logic [7:0]  busData,
  input  wire logic [7:0]  lineBufferData,
  output logic             busRequest,
  output logic [15:0]      busAddr,
  output logic             refreshCycle,
  output logic             lineBufferRead,
  output logic [7:0]       nameByte,
  output logic             nameByteValid,
  output logic [7:0]       specialData,
  output logic             specialDataValid,
  output logic [15:0]      memScanCounter,
  output logic [7:0]       dmaRingState,
  output logic             pixelValid,
  input  wire logic        pixelReady,
  output logic [3:0]       pixelPair
);

  typedef struct packed {
    logic [DMA_RING_BITS-1:0]   dmaRing;
    logic [SHIFT_RING_BITS-1:0] shiftRing;
    logic [GFX_BITS-1:0]        shiftReg;
    logic [3:0]                 bitsLeft;
    logic [15:0]                msc;
    logic                       busReq;
    logic [15:0]                busAddr;
    logic                       refresh;
    logic                       lbRead;
    logic                       pendName;
    logic                       pendGfx;
    logic                       pendSpecial;
    logic                       pendBuffer;
    logic [7:0]                 nameByte;
    logic                       nameValid;
    logic [7:0]                 specialData;
    logic                       specialValid;
  } pfd_state_s;

  pfd_state_s state_q;
  pfd_state_s state_d;

  pfd_rate_e  fetchRate;
  pfd_rate_e  shiftRate;
  logic       oneBit;
  logic       charMode;
  logic [6:0] scrollDelay;
  logic [6:0] startCycle;
  logic [6:0] stopCycle;
  logic [6:0] wideStopCycle;
  logic       nameTap;
  logic       gfxTap;
  logic       nameBus;
  logic       gfxBus;
  logic       gfxBuffer;
  logic       suppress;
  logic       pfFetch;
  logic       anyFetch;
  logic [3:0] shiftMask;
  logic       pushReady;
  logic       pushValid;
  logic [3:0] pushData;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode and playfield window

  always_comb begin
    fetchRate = pfd_fetch_rate(displayInstructionCode);
    shiftRate = pfd_shift_rate(displayInstructionCode);
    oneBit    = pfd_one_bit_pixels(displayInstructionCode);
    charMode  = pfd_char_mode(displayInstructionCode);
    // Each two colour clocks of scroll push start and stop one cycle later
    scrollDelay = {4'h0, horizontalScrollReg[3:1]};
    case (fetchControlReg)
      WIDTH_NARROW: begin
        startCycle = START_NARROW + scrollDelay;
        stopCycle  = STOP_NARROW + scrollDelay;
      end
      WIDTH_NORMAL: begin
        startCycle = START_NORMAL + scrollDelay;
        stopCycle  = STOP_NORMAL + scrollDelay;
      end
      default: begin
        startCycle = START_WIDE + scrollDelay;
        stopCycle  = STOP_WIDE + scrollDelay;
      end
    endcase
    wideStopCycle = STOP_WIDE + scrollDelay;
    case (shiftRate)
      RATE_SLOW: shiftMask = SHIFT_MASK_SLOW;
      RATE_MED:  shiftMask = SHIFT_MASK_MED;
      default:   shiftMask = SHIFT_MASK_FAST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fetch requests from the ring taps

  always_comb begin
    nameTap = charMode && state_q.dmaRing[TAP_NAME];
    gfxTap  = charMode ? state_q.dmaRing[TAP_CHAR_DATA] : state_q.dmaRing[TAP_BITMAP];
    // Names and bitmap bytes come from memory only on the first line; repeats read bitmap bytes from the buffer
    nameBus   = nameTap && firstScanLine;
    gfxBus    = gfxTap && (charMode || firstScanLine);
    gfxBuffer = gfxTap && !charMode && !firstScanLine;
    suppress  = ((hposCycle >= SUPPRESS_FIRST) && (hposCycle <= SUPPRESS_LAST))
                || (hposCycle == 7'h00);
    pfFetch   = (nameBus || gfxBus) && !suppress && (fetchControlReg != WIDTH_OFF);
    anyFetch  = pfFetch || specialRequest;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [DMA_RING_BITS-1:0] ring;
    logic [15:0]              addr;
    logic                     pulse;
    logic [1:0]               pix [2];
    logic [7:0]               gfxByte;
    logic                     gfxArrives;
    ring       = '0;
    addr       = ADDR_ALL_ONES;
    pulse      = 1'b0;
    pix[0]     = 2'h0;
    pix[1]     = 2'h0;
    gfxByte    = '0;
    gfxArrives = 1'b0;
    state_d    = state_q;

    // Physical eight-bit shift; only the low part recirculates at faster rates
    ring[DMA_RING_BITS-1:1] = state_q.dmaRing[DMA_RING_BITS-2:0];
    case (fetchRate)
      RATE_FAST: ring[0] = state_q.dmaRing[1];
      RATE_MED:  ring[0] = state_q.dmaRing[3];
      RATE_SLOW: ring[0] = state_q.dmaRing[7];
      default:   ring[0] = state_q.dmaRing[1];
    endcase
    // Start and stop act on the same ring slot; a stop that falls on a
    // cycle where that slot is empty misses and the ring keeps going
    if ((fetchControlReg != WIDTH_OFF) && (hposCycle == startCycle)) begin
      ring[0] = 1'b1;
    end
    if ((hposCycle == stopCycle) || (hposCycle == wideStopCycle)) begin
      ring[0] = 1'b0;
    end
    if (modeBlankOrJump || verticalBlank) begin
      ring = '0;
    end
    // No clear at line end: stray bits carry into the next line
    state_d.dmaRing = ring;

    if (mscLoad) begin
      state_d.msc = mscLoadAddr;
    end else if ((nameTap || (gfxTap && !charMode)) && firstScanLine) begin
      state_d.msc = state_q.msc + 16'h0001;
    end

    // All colliding requests share one bus address
    if (pfFetch && nameBus) begin
      addr = addr & state_q.msc;
    end
    if (pfFetch && gfxBus) begin
      addr = addr & (charMode ? charDataAddr : state_q.msc);
    end
    if (specialRequest) begin
      addr = addr & specialAddr;
    end
    state_d.busReq      = anyFetch;
    state_d.busAddr     = anyFetch ? addr : state_q.busAddr;
    state_d.refresh     = refreshWanted && !anyFetch;
    state_d.lbRead      = gfxBuffer;
    // Suppressed fetches are virtual but still load whatever the bus carries
    state_d.pendName    = nameBus;
    state_d.pendGfx     = gfxBus;
    state_d.pendBuffer  = gfxBuffer;
    state_d.pendSpecial = specialRequest;

    // Returned byte is handed to every request of the previous cycle
    state_d.nameValid    = state_q.pendName;
    state_d.specialValid = state_q.pendSpecial;
    if (state_q.pendName) begin
      state_d.nameByte = busData;
    end
    if (state_q.pendSpecial) begin
      state_d.specialData = busData;
    end
    if (state_q.pendGfx) begin
      gfxByte    = busData;
      gfxArrives = 1'b1;
    end else if (state_q.pendBuffer) begin
      gfxByte    = lineBufferData;
      gfxArrives = 1'b1;
    end

    // Shift stage: two colour clocks per machine cycle; it holds while the
    // pixel queue is full, but held bits are still merged by loads and cleared in cycles 0-7
    if (pushReady) begin
      for (int s = 0; s < 2; s++) begin
        pulse = |(state_d.shiftRing & shiftMask);
        if (state_d.bitsLeft == 4'h0) begin
          pix[s] = 2'h0;
        end else if (oneBit) begin
          pix[s] = {1'b0, state_d.shiftReg[7]};
        end else begin
          pix[s] = state_d.shiftReg[7:6];
        end
        if (pulse) begin
          if (oneBit || (state_d.bitsLeft < 4'h2)) begin
            state_d.shiftReg = {state_d.shiftReg[6:0], 1'b0};
            state_d.bitsLeft = (state_d.bitsLeft == 4'h0) ? 4'h0 : state_d.bitsLeft - 4'h1;
          end else begin
            state_d.shiftReg = {state_d.shiftReg[5:0], 2'h0};
            state_d.bitsLeft = state_d.bitsLeft - 4'h2;
          end
        end
        // Ring keeps turning past playfield stop until cleared in cycles 0-7
        state_d.shiftRing = {state_d.shiftRing[2:0], state_d.shiftRing[3]};
      end
    end
    if (gfxArrives) begin
      // Extra loads overlap old data, so bytes are merged, not replaced
      state_d.shiftReg    = state_d.shiftReg | gfxByte;
      state_d.bitsLeft    = 4'(GFX_BITS);
      state_d.shiftRing[0] = 1'b1;
    end
    if (hposCycle <= SPECIAL_LAST_CYCLE) begin
      state_d.shiftRing = '0;
      state_d.shiftReg  = '0;
      state_d.bitsLeft  = 4'h0;
    end
    pushData  = {pix[0], pix[1]};
    pushValid = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel queue toward the colour generator

  pfd_fifo #(
    .WIDTH (4),
    .DEPTH (FIFO_DEPTH)
  ) u_pixel_fifo (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (pixelValid),
    .outReady (pixelReady),
    .outData  (pixelPair)
  );

  assign busRequest       = state_q.busReq;
  assign busAddr          = state_q.busAddr;
  assign refreshCycle     = state_q.refresh;
  assign lineBufferRead   = state_q.lbRead;
  assign nameByte         = state_q.nameByte;
  assign nameByteValid    = state_q.nameValid;
  assign specialData      = state_q.specialData;
  assign specialDataValid = state_q.specialValid;
  assign memScanCounter   = state_q.msc;
  assign dmaRingState     = state_q.dmaRing;
endmodule : pfd_playfield_dma

// File: tb/pfd_playfield_dma_monitor.sv
`timescale 1ns/1ps
module pfd_playfield_dma_monitor
  import pfd_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [6:0]  hposCycle,
  input wire logic        modeBlankOrJump,
  input wire logic        verticalBlank,
  input wire logic [1:0]  fetchControlReg,
  input wire logic        mscLoad,
  input wire logic        specialRequest,
  input wire logic [15:0] specialAddr,
  input wire logic        refreshWanted,
  input wire logic [7:0]  busData,
  input wire logic        busRequest,
  input wire logic [15:0] busAddr,
  input wire logic        refreshCycle,
  input wire logic [7:0]  specialData,
  input wire logic        specialDataValid,
  input wire logic [15:0] memScanCounter,
  input wire logic [7:0]  dmaRingState,
  input wire logic        pixelValid,
  input wire logic        pixelReady,
  input wire logic [3:0]  pixelPair
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence special_issue_s;
    specialRequest ##1 busRequest;
  endsequence
  sequence special_reply_s;
    specialDataValid && (specialData == $past(busData));
  endsequence
  special_fetch_a: assert property (specialRequest |-> special_issue_s ##1 special_reply_s)
    else $error("special fetch not issued or answered");
  addr_and_a: assert property ($past(specialRequest) |-> (busAddr & ~$past(specialAddr)) == 16'h0)
    else $error("bus address not covered by special address");
  refresh_excl_a: assert property (refreshCycle |-> !busRequest && !$past(specialRequest))
    else $error("refresh overlaps a fetch");
  refresh_idle_a: assert property ($past(reset_n) && $past(refreshWanted) && !$past(specialRequest)
      && $past(dmaRingState) == 8'h0 |-> refreshCycle)
    else $error("idle refresh not issued");
  suppress_win_a: assert property (($past(hposCycle) inside {[SUPPRESS_FIRST:SUPPRESS_LAST], 7'h0})
      && !$past(specialRequest) |-> !busRequest)
    else $error("playfield fetch on bus in suppressed cycle");
  width_off_a: assert property ($past(fetchControlReg) == WIDTH_OFF && !$past(specialRequest)
      |-> !busRequest)
    else $error("bus fetch with playfield off");
  blank_clear_a: assert property ($past(reset_n) && ($past(verticalBlank) || $past(modeBlankOrJump))
      |-> dmaRingState == 8'h0)
    else $error("fetch ring not cleared");
  idle_ring_a: assert property ($past(dmaRingState) == 8'h0 && !$past(specialRequest) |-> !busRequest)
    else $error("bus fetch with empty ring");
  msc_step_a: assert property ($past(reset_n) && !$past(mscLoad) |-> memScanCounter ==
      $past(memScanCounter) || memScanCounter == $past(memScanCounter) + 16'h1)
    else $error("scan counter jumped");
  pixel_hold_a: assert property (pixelValid && !pixelReady |=> pixelValid && $stable(pixelPair))
    else $error("pixel lost while stalled");
endmodule : pfd_playfield_dma_monitor

bind pfd_playfield_dma pfd_playfield_dma_monitor u_monitor (.*);

// File: tb/pfd_mem_model.sv
`timescale 1ns/1ps
module pfd_mem_model (
  input wire logic        sys_clk,
  input wire logic        busRequest,
  input wire logic [15:0] busAddr,
  input wire logic        lineBufferRead,
  output logic     [7:0]  busData,
  output logic     [7:0]  lineBufferData
);
  // Undriven bus toggles so a stale capture never looks like real data
  logic [7:0] floatQ = 8'h3C;
  always_ff @(posedge sys_clk) floatQ <= ~floatQ;
  // One byte per bus cycle, whoever asked for it
  assign busData        = busRequest ? (busAddr[7:0] ^ 8'hA5) : floatQ;
  assign lineBufferData = lineBufferRead ? 8'h96 : ~floatQ;
endmodule : pfd_mem_model

// File: tb/pfd_playfield_dma_tb.sv
`timescale 1ns/1ps
module pfd_playfield_dma_tb
  import pfd_pkg::*;
;
  logic        sys_clk, reset_n, modeBlankOrJump, verticalBlank, firstScanLine, mscLoad;
  logic        specialRequest, refreshWanted, busRequest, refreshCycle, lineBufferRead;
  logic        nameByteValid, specialDataValid, pixelValid, pixelReady;
  logic [6:0]  hposCycle;
  logic [3:0]  displayInstructionCode, horizontalScrollReg, pixelPair;
  logic [1:0]  fetchControlReg;
  logic [15:0] mscLoadAddr, charDataAddr, specialAddr, busAddr, memScanCounter, specBase;
  logic [7:0]  busData, lineBufferData, nameByte, specialData, dmaRingState;
  int          errors = 0;
  int          checks_done = 0;
  int          busCnt, lbCnt, refCnt, svCnt, pixNz, eb, nvCnt;
  logic [3:0]  modes [5] = '{4'h2, 4'h6, 4'h8, 4'hA, 4'hE};

  always #5 sys_clk = ~sys_clk;

  pfd_playfield_dma #(.FIFO_DEPTH(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .hposCycle(hposCycle), .displayInstructionCode(displayInstructionCode),
    .modeBlankOrJump(modeBlankOrJump), .verticalBlank(verticalBlank),
    .firstScanLine(firstScanLine), .fetchControlReg(fetchControlReg),
    .horizontalScrollReg(horizontalScrollReg), .mscLoad(mscLoad), .mscLoadAddr(mscLoadAddr),
    .charDataAddr(charDataAddr), .specialRequest(specialRequest), .specialAddr(specialAddr),
    .refreshWanted(refreshWanted), .busData(busData), .lineBufferData(lineBufferData),
    .busRequest(busRequest), .busAddr(busAddr), .refreshCycle(refreshCycle),
    .lineBufferRead(lineBufferRead), .nameByte(nameByte), .nameByteValid(nameByteValid),
    .specialData(specialData), .specialDataValid(specialDataValid),
    .memScanCounter(memScanCounter), .dmaRingState(dmaRingState), .pixelValid(pixelValid),
    .pixelReady(pixelReady), .pixelPair(pixelPair));

  pfd_mem_model mem (.sys_clk(sys_clk), .busRequest(busRequest), .busAddr(busAddr),
    .lineBufferRead(lineBufferRead), .busData(busData), .lineBufferData(lineBufferData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : cmp

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Bytes per line: width sets the narrow/normal/wide base, mode sets fetch density
  function automatic int expBytes(input logic [3:0] m, input logic [1:0] w);
    int base;
    base = (w == 2'h1) ? 8 : (w == 2'h2) ? 10 : 12;
    if (m == 4'h8 || m == 4'h9) return base;
    if (m inside {4'h6, 4'h7, 4'hA, 4'hB, 4'hC}) return 2 * base;
    return 4 * base;
  endfunction : expBytes

  // One scan line; the scan counter reloads at its last cycle, so every line after the first starts at 1000
  task automatic runLine(input int scrollAt, input logic [3:0] scrollNew, input int specAt);
    busCnt = 0; lbCnt = 0; refCnt = 0; svCnt = 0; pixNz = 0; nvCnt = 0;
    for (int h = 0; h < 114; h++) begin
      @(negedge sys_clk);
      busCnt += int'(busRequest);
      lbCnt += int'(lineBufferRead);
      refCnt += int'(refreshCycle);
      svCnt += int'(specialDataValid);
      nvCnt += int'(nameByteValid);
      if (pixelValid && pixelReady && pixelPair != 4'h0) pixNz++;
      hposCycle = 7'(h);
      if (h == scrollAt) horizontalScrollReg = scrollNew;
      specialRequest = (h >= specAt) && (h < specAt + 8);
      specialAddr = specBase + 16'(h - specAt);
      mscLoad = (h == 113);
    end
  endtask : runLine

  task automatic modeLine(input logic [3:0] m, input logic [1:0] w, input logic first);
    verticalBlank = 1'b0; modeBlankOrJump = 1'b0;
    displayInstructionCode = m; fetchControlReg = w; firstScanLine = first;
  endtask : modeLine

  task automatic blankLine();
    verticalBlank = 1'b1; horizontalScrollReg = 4'h0;
    runLine(-1, 4'h0, 200);
  endtask : blankLine
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0; reset_n = 1'b0; hposCycle = 7'h0; displayInstructionCode = 4'h2;
    modeBlankOrJump = 1'b0; verticalBlank = 1'b1; firstScanLine = 1'b1; fetchControlReg = 2'h2;
    horizontalScrollReg = 4'h0; mscLoad = 1'b0; mscLoadAddr = 16'h1000; charDataAddr = 16'h8000;
    specialRequest = 1'b0; specialAddr = 16'h0; refreshWanted = 1'b1; pixelReady = 1'b1;
    specBase = 16'h2000;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    cmp({busRequest, refreshCycle, pixelValid, 5'h0, dmaRingState}, 16'h0, "reset flags");
    cmp(memScanCounter, 16'h0, "reset scan counter");
    // Vertical blank with eight special fetches in cycles 0..7
    runLine(-1, 4'h0, 0);
    cmp(16'(refCnt), 16'd106, "refresh count");
    cmp(16'(svCnt), 16'd8, "special replies");
    cmp({8'h0, specialData}, 16'h00A2, "special byte");
    cmp({11'h0, pixelValid, pixelPair}, 16'h0010, "empty shift pixel");
    foreach (modes[i]) begin
      for (int w = 1; w < 4; w++) begin
        eb = expBytes(modes[i], 2'(w));
        modeLine(modes[i], 2'(w), 1'b1);
        runLine(-1, 4'h0, 200);
        cmp(memScanCounter - 16'h1000, 16'(eb), "bytes per line");
        cmp(16'(nvCnt), 16'(modes[i] < 4'h8 ? eb : 0), "name bytes");
        if (w != 3) cmp(16'(busCnt), 16'(modes[i] < 4'h8 ? 2 * eb : eb), "bus fetches");
        if (modes[i] == 4'hE) cmp(16'(pixNz != 0), 16'h1, "pixels shifted");
        blankLine();
      end
    end
    // Repeated line replays from the buffer with the pixel sink stalled
    modeLine(4'hE, 2'h2, 1'b1);
    runLine(-1, 4'h0, 200);
    firstScanLine = 1'b0;
    pixelReady = 1'b0;
    runLine(-1, 4'h0, 200);
    cmp(16'(lbCnt), 16'd40, "buffer reads");
    cmp(16'(busCnt), 16'd0, "no bus on repeat");
    cmp(memScanCounter, 16'h1000, "counter held on repeat");
    pixelReady = 1'b1;
    blankLine();
    // Playfield off: no start injection, no fetches, counter untouched
    modeLine(4'hE, 2'h0, 1'b1);
    runLine(-1, 4'h0, 200);
    cmp(16'(busCnt), 16'd0, "no fetch with playfield off");
    cmp(memScanCounter, 16'h1000, "counter held with playfield off");
    // Specials landing on an active character line
    specBase = 16'hF0F0;
    modeLine(4'h2, 2'h2, 1'b1);
    runLine(-1, 4'h0, 30);
    cmp(16'(busCnt), 16'd80, "merged bus cycles");
    cmp(16'(svCnt), 16'd8, "merged special replies");
    cmp({8'h0, specialData}, 16'h00A4, "merged special byte");
    cmp({8'h0, nameByte}, 16'h0082, "last name byte");
    blankLine();
    // Scroll moved after start: ring misses its stop and outlives the line
    for (int k = 0; k < 2; k++) begin
      horizontalScrollReg = 4'h0;
      modeLine(4'h8, 2'h2, 1'b1);
      runLine(40, 4'h4, 200);
      cmp(16'(dmaRingState != 8'h0), 16'h1, "ring still running");
      runLine(-1, 4'h4, 200);
      cmp(16'(dmaRingState != 8'h0), 16'h1, "ring carried over");
      modeBlankOrJump = (k == 0);
      verticalBlank = (k == 1);
      runLine(-1, 4'h0, 200);
      cmp({8'h0, dmaRingState}, 16'h0, "ring cleared");
    end
    results();
  end

  initial begin
    #200_000;
    errors++;
    $display("Error at %0t: run did not finish", $time);
    results();
  end
endmodule : pfd_playfield_dma_tb
